// File: dnhm_top.v
// Hopping NCO bank and complex mixer for both down-conversion channels.
// Assumes samples arrive every clock from logic on clk_i, hop pins are
// asynchronous, and software uses a plain one-cycle register port.
//
// Operation
// - Each sample goes either straight out (bypass) or through the mixer path.
// - Channel B mirrors A; its input follows the binding bit, its NCO its own pins or field.
// - Each NCO runs from a 32-bit tuning word and its exponential multiplies the real sample.
// - Each channel has four oscillators, each with own tuning word, phase offset and accumulator.
// - All accumulators advance every clock, selected or not.
// - A hop follows any change of the asynchronous hop pins, with no sample alignment.
// - Hop pin to mixer takes about 36 to 40 cycles and sample to mixer about 36 cycles.
// - Source control 1 picks the oscillator by pins, 0 (reset) by the register field.
// - Codes 00 to 11 of the active source pick oscillators 0 to 3; the other source is ignored.
// - Each accumulator takes its own tuning word (rational option) and its own phase offset.
// - Divider zero is basic mode: the accumulator adds the tuning word modulo 2^32 each clock.
// - Rewriting a tuning word live may leave phase undefined; software resynchronizes if needed.
// - The 16-bit phase offset is left-justified into 32 bits and added to the phase.
`timescale 1ns/1ns
`include "dnhm_defs.vh"

module dnhm_top (
  input wire clk_i, // Device clock, 20 MHz
  input wire rst_b_i, // Synchronous reset, active low
  input wire [5:0] reg_addr_i, // Register word address
  input wire [31:0] reg_wdata_i, // Register write data
  input wire reg_wr_i, // Write strobe
  input wire reg_rd_i, // Read strobe
  output wire [31:0] reg_rdata_o, // Read data, cycle after strobe
  input wire [11:0] adc_a_i, // Converter sample channel A
  input wire [11:0] adc_b_i, // Converter sample channel B
  input wire [1:0] hop_pins_a_i, // Async hop pins channel A
  input wire [1:0] hop_pins_b_i, // Async hop pins channel B
  output wire [15:0] i_a_o, // In-phase out channel A
  output wire [15:0] q_a_o, // Quadrature out channel A
  output wire [15:0] i_b_o, // In-phase out channel B
  output wire [15:0] q_b_o // Quadrature out channel B
);

  // ****************************************************************
  // Sine table helpers
  // ****************************************************************

  // Quarter-wave sine, 16 steps per quarter, full scale 0x7FFF
  function [15:0] dnhm_qsin;
    input [4:0] k;
    begin
      case (k)
        5'h00: dnhm_qsin = 16'h0000;
        5'h01: dnhm_qsin = 16'h0C8C;
        5'h02: dnhm_qsin = 16'h18F9;
        5'h03: dnhm_qsin = 16'h2528;
        5'h04: dnhm_qsin = 16'h30FB;
        5'h05: dnhm_qsin = 16'h3C56;
        5'h06: dnhm_qsin = 16'h471C;
        5'h07: dnhm_qsin = 16'h5133;
        5'h08: dnhm_qsin = 16'h5A82;
        5'h09: dnhm_qsin = 16'h62F1;
        5'h0A: dnhm_qsin = 16'h6A6D;
        5'h0B: dnhm_qsin = 16'h70E2;
        5'h0C: dnhm_qsin = 16'h7641;
        5'h0D: dnhm_qsin = 16'h7A7C;
        5'h0E: dnhm_qsin = 16'h7D89;
        5'h0F: dnhm_qsin = 16'h7F61;
        default: dnhm_qsin = 16'h7FFF;
      endcase
    end
  endfunction

  // Full-circle sine of a 6-bit phase by quadrant symmetry
  function [15:0] dnhm_sin;
    input [5:0] p;
    reg [15:0] mag;
    begin
      mag = 16'h0000;
      if (p[4]) begin
        mag = dnhm_qsin(5'h10 - {1'b0, p[3:0]});
      end else begin
        mag = dnhm_qsin({1'b0, p[3:0]});
      end
      if (p[5]) begin
        dnhm_sin = 16'h0000 - mag;
      end else begin
        dnhm_sin = mag;
      end
    end
  endfunction

  // ****************************************************************
  // Register file
  // ****************************************************************
  reg [7:0] ctrl_ff;
  reg [15:0] rdiv_ff;
  reg [31:0] tw_ff [0:7];
  reg [15:0] ph_ff [0:7];
  reg [31:0] rdata_ff;
  reg [31:0] nxt_rdata;
  reg [3:0] hop_s1_ff;
  reg [3:0] hop_s2_ff;
  integer r;

  wire ddc_en = ctrl_ff[`DNHM_CTRL_DDC_EN];
  wire select_source_ctrl = ctrl_ff[`DNHM_CTRL_SRC];
  wire chan_b_input_binding = ctrl_ff[`DNHM_CTRL_BIND_B];
  wire [1:0] osc_select_reg_a = ctrl_ff[`DNHM_CTRL_SEL_A_LO +: 2];
  wire [1:0] osc_select_reg_b = ctrl_ff[`DNHM_CTRL_SEL_B_LO +: 2];
  wire [3:0] sel_eff;

  // Register writes; tuning words apply at once, phase may jump
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      ctrl_ff <= `DNHM_RST_CTRL;
      rdiv_ff <= `DNHM_RST_RDIV;
      for (r = 0; r < 8; r = r + 1) begin
        tw_ff[r] <= `DNHM_RST_TW;
        ph_ff[r] <= `DNHM_RST_PH;
      end
    end else if (reg_wr_i) begin
      if (reg_addr_i == `DNHM_ADDR_CTRL) begin
        ctrl_ff <= reg_wdata_i[7:0];
      end
      if (reg_addr_i == `DNHM_ADDR_RDIV) begin
        rdiv_ff <= reg_wdata_i[15:0];
      end
      if (reg_addr_i[5:3] == `DNHM_ADDR_TW_BASE) begin
        tw_ff[reg_addr_i[2:0]] <= reg_wdata_i;
      end
      if (reg_addr_i[5:3] == `DNHM_ADDR_PH_BASE) begin
        ph_ff[reg_addr_i[2:0]] <= reg_wdata_i[15:0];
      end
    end
  end

  // Read mux; unmapped words read zero
  always @* begin
    nxt_rdata = 32'h0000_0000;
    if (reg_rd_i) begin
      if (reg_addr_i == `DNHM_ADDR_CTRL) begin
        nxt_rdata = {24'h00_0000, ctrl_ff};
      end else if (reg_addr_i == `DNHM_ADDR_RDIV) begin
        nxt_rdata = {16'h0000, rdiv_ff};
      end else if (reg_addr_i == `DNHM_ADDR_STATUS) begin
        nxt_rdata = {24'h00_0000, hop_s2_ff, sel_eff};
      end else if (reg_addr_i[5:3] == `DNHM_ADDR_TW_BASE) begin
        nxt_rdata = tw_ff[reg_addr_i[2:0]];
      end else if (reg_addr_i[5:3] == `DNHM_ADDR_PH_BASE) begin
        nxt_rdata = {16'h0000, ph_ff[reg_addr_i[2:0]]};
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata_o = rdata_ff;

  // ****************************************************************
  // Hop pin synchroniser and oscillator selection
  // ****************************************************************

  // Two flops on the asynchronous pins; any change is a hop
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      hop_s1_ff <= 4'h0;
      hop_s2_ff <= 4'h0;
    end else begin
      hop_s1_ff <= {hop_pins_b_i, hop_pins_a_i};
      hop_s2_ff <= hop_s1_ff;
    end
  end

  // Active source picks the index, other source ignored
  assign sel_eff = select_source_ctrl ? hop_s2_ff :
                   {osc_select_reg_b, osc_select_reg_a};

  // ****************************************************************
  // Phase accumulators
  // ****************************************************************
  reg [31:0] acc_ff [0:7];
  reg [21:0] rcnt_ff;
  wire rational = (rdiv_ff != `DNHM_RST_RDIV);
  wire [21:0] rlimit = {rdiv_ff, {`DNHM_RDIV_SHIFT{1'b0}}} - 22'h000001;
  wire rwrap = rational && (rcnt_ff == rlimit);
  integer a;

  // Rational period counter: 64 * divider clocks per step period
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      rcnt_ff <= 22'h000000;
    end else if (!rational || rwrap) begin
      rcnt_ff <= 22'h000000;
    end else begin
      rcnt_ff <= rcnt_ff + 22'h000001;
    end
  end

  // All eight accumulators run every clock, selected or not
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      for (a = 0; a < 8; a = a + 1) begin
        acc_ff[a] <= 32'h0000_0000;
      end
    end else begin
      for (a = 0; a < 8; a = a + 1) begin
        if (rwrap) begin
          acc_ff[a] <= 32'h0000_0000;
        end else begin
          acc_ff[a] <= acc_ff[a] + tw_ff[a];
        end
      end
    end
  end

  // ****************************************************************
  // Per-channel delay lines and mixer
  // ****************************************************************
  wire [15:0] i_out [0:1];
  wire [15:0] q_out [0:1];

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      localparam [0:0] CH = (ch == 1) ? 1'b1 : 1'b0;
      reg [11:0] smp_dly_ff [0:`DNHM_SMP_DLY-1];
      reg [1:0] sel_dly_ff [0:`DNHM_HOP_DLY-1];
      reg [31:0] phase_ff;
      reg [15:0] cos_ff;
      reg [15:0] sin_ff;
      reg [15:0] i_ff;
      reg [15:0] q_ff;
      wire [11:0] smp_src;
      wire [11:0] smp_al = smp_dly_ff[`DNHM_SMP_DLY-1];
      wire [1:0] sel_al = sel_dly_ff[`DNHM_HOP_DLY-1];
      wire signed [27:0] prod_i = $signed(smp_al) * $signed(cos_ff);
      wire signed [27:0] prod_q = $signed(smp_al) * $signed(sin_ff);
      integer k;

      // Channel B input follows the binding bit
      if (ch == 0) begin : g_src_a
        assign smp_src = adc_a_i;
      end else begin : g_src_b
        assign smp_src = chan_b_input_binding ? adc_a_i : adc_b_i;
      end

      // Matched delay lines for sample and selection
      always @(posedge clk_i) begin
        if (!rst_b_i) begin
          for (k = 0; k < `DNHM_SMP_DLY; k = k + 1) begin
            smp_dly_ff[k] <= 12'h000;
          end
          for (k = 0; k < `DNHM_HOP_DLY; k = k + 1) begin
            sel_dly_ff[k] <= 2'h0;
          end
        end else begin
          smp_dly_ff[0] <= smp_src;
          for (k = 1; k < `DNHM_SMP_DLY; k = k + 1) begin
            smp_dly_ff[k] <= smp_dly_ff[k-1];
          end
          sel_dly_ff[0] <= sel_eff[ch*2 +: 2];
          for (k = 1; k < `DNHM_HOP_DLY; k = k + 1) begin
            sel_dly_ff[k] <= sel_dly_ff[k-1];
          end
        end
      end

      // Selected phase plus left-justified offset, then sine lookup
      always @(posedge clk_i) begin
        if (!rst_b_i) begin
          phase_ff <= 32'h0000_0000;
          cos_ff <= 16'h0000;
          sin_ff <= 16'h0000;
        end else begin
          phase_ff <= acc_ff[{CH, sel_al}] + {ph_ff[{CH, sel_al}], 16'h0000};
          cos_ff <= dnhm_sin(phase_ff[31:26] + 6'h10);
          sin_ff <= dnhm_sin(phase_ff[31:26]);
        end
      end

      // Mixer or bypass output stage
      always @(posedge clk_i) begin
        if (!rst_b_i) begin
          i_ff <= 16'h0000;
          q_ff <= 16'h0000;
        end else if (ddc_en) begin
          i_ff <= prod_i[26:11];
          q_ff <= prod_q[26:11];
        end else begin
          i_ff <= {smp_al, 4'h0};
          q_ff <= 16'h0000;
        end
      end

      assign i_out[ch] = i_ff;
      assign q_out[ch] = q_ff;
    end
  endgenerate

  // Output ports straight from the stage flops
  assign i_a_o = i_out[0];
  assign q_a_o = q_out[0];
  assign i_b_o = i_out[1];
  assign q_b_o = q_out[1];

endmodule // dnhm_top

// File: dnhm_defs.vh
// Constants for the hopping NCO down-converter front end.
// Assumes a 20 MHz device clock and a plain one-cycle register port.
`ifndef DNHM_DEFS_VH
`define DNHM_DEFS_VH

// ****************************************************************
// Register offsets (word addresses on the 6-bit register port)
// ****************************************************************
`define DNHM_ADDR_CTRL 6'h00
`define DNHM_ADDR_RDIV 6'h01
`define DNHM_ADDR_STATUS 6'h02
`define DNHM_ADDR_TW_BASE 3'h2
`define DNHM_ADDR_PH_BASE 3'h3

// ****************************************************************
// Control register fields
// ****************************************************************
`define DNHM_CTRL_DDC_EN 0
`define DNHM_CTRL_SRC 1
`define DNHM_CTRL_BIND_B 2
`define DNHM_CTRL_SEL_A_LO 4
`define DNHM_CTRL_SEL_B_LO 6

// ****************************************************************
// Reset values
// ****************************************************************
`define DNHM_RST_CTRL 8'h00
`define DNHM_RST_RDIV 16'h0000
`define DNHM_RST_TW 32'h0000_0000
`define DNHM_RST_PH 16'h0000

// ****************************************************************
// Timing counts, in device clock cycles, and the divider shift in bits
// ****************************************************************
`define DNHM_SMP_DLY 35
`define DNHM_HOP_DLY 31
`define DNHM_RDIV_SHIFT 6

`endif

// File: dnhm_adc_model.sv
// Converter core model: one sample per clock on each channel.
// Assumes the bench picks the sample levels; runs on the device clock.
`timescale 1ns/1ns
module dnhm_adc_model (
  input wire clk_i, // Device clock
  input wire [11:0] lvl_a_i, // Level for channel A
  input wire [11:0] lvl_b_i, // Level for channel B
  output reg [11:0] adc_a_o = 12'h000, // Sample stream A
  output reg [11:0] adc_b_o = 12'h000 // Sample stream B
);
  // ********************
  // Sample launch
  // ********************
  // A fresh sample every edge, as the core delivers
  always @(posedge clk_i) begin
    adc_a_o <= lvl_a_i;
    adc_b_o <= lvl_b_i;
  end
endmodule // dnhm_adc_model

// File: dnhm_top_assertions.sv
// Port checker of the NCO mixer: read data, status, bypass and mix paths.
// Assumes the register map and the 36-cycle sample path of the design.
`timescale 1ns/1ns
`include "dnhm_defs.vh"
module dnhm_chk (
  input wire clk_i, // Device clock
  input wire rst_b_i, // Reset, active low
  input wire [5:0] reg_addr_i, // Register address
  input wire [31:0] reg_wdata_i, // Write data
  input wire reg_wr_i, // Write strobe
  input wire reg_rd_i, // Read strobe
  input wire [31:0] reg_rdata_o, // Read data
  input wire [11:0] adc_a_i, // Sample A
  input wire [11:0] adc_b_i, // Sample B
  input wire [1:0] hop_pins_a_i, // Hop pins A
  input wire [1:0] hop_pins_b_i, // Hop pins B
  input wire [15:0] i_a_o, // I out A
  input wire [15:0] q_a_o, // Q out A
  input wire [15:0] i_b_o, // I out B
  input wire [15:0] q_b_o // Q out B
);
  // ********************
  // Control shadow
  // ********************
  reg [7:0] ctrl_ff;
  reg [5:0] quiet_ff;
  wire [11:0] b_src;
  wire calm;
  // Channel B source and settled flag
  assign b_src = ctrl_ff[`DNHM_CTRL_BIND_B] ? adc_a_i : adc_b_i;
  assign calm = quiet_ff > 6'h28;
  // Mirror control writes, count cycles since the last one
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      ctrl_ff <= 8'h00;
      quiet_ff <= 6'h00;
    end else if (reg_wr_i && reg_addr_i == `DNHM_ADDR_CTRL) begin
      ctrl_ff <= reg_wdata_i[7:0];
      quiet_ff <= 6'h00;
    end else if (quiet_ff != 6'h3F) begin
      quiet_ff <= quiet_ff + 6'h01;
    end
  end
  // ********************
  // Properties
  // ********************
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence pins_quiet;
    ($stable(hop_pins_a_i) && $stable(hop_pins_b_i))[*4];
  endsequence
  sequence status_rd;
    reg_rd_i && reg_addr_i == `DNHM_ADDR_STATUS && quiet_ff > 6'h04;
  endsequence
  rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0000_0000)
    else $error("read data not zero without read");
  unmapped_read_a: assert property (reg_rd_i && reg_addr_i inside {[6'h03:6'h0F], [6'h20:6'h3F]}
    |=> reg_rdata_o == 32'h0000_0000) else $error("unmapped read not zero");
  ctrl_readback_a: assert property (reg_rd_i && reg_addr_i == `DNHM_ADDR_CTRL
    |=> reg_rdata_o == {24'h000000, ctrl_ff}) else $error("control readback wrong");
  status_select_a: assert property (status_rd ##0 !ctrl_ff[1]
    |=> reg_rdata_o[3:0] == ctrl_ff[7:4]) else $error("register selection not used");
  status_pins_a: assert property (pins_quiet ##0 status_rd ##0 ctrl_ff[1]
    |=> reg_rdata_o[7:0] == {$past(hop_pins_b_i), $past(hop_pins_a_i),
    $past(hop_pins_b_i), $past(hop_pins_a_i)}) else $error("pin selection not used");
  bypass_path_a: assert property (!ctrl_ff[0] && calm
    |-> i_a_o == {$past(adc_a_i, 36), 4'h0} && q_a_o == 16'h0000)
    else $error("bypass A output wrong");
  bypass_bound_a: assert property (!ctrl_ff[0] && calm
    |-> i_b_o == {$past(b_src, 36), 4'h0} && q_b_o == 16'h0000)
    else $error("bypass B output wrong");
  mix_silence_a: assert property (ctrl_ff[0] && calm && $past(adc_a_i, 36) == 12'h000
    |-> i_a_o == 16'h0000 && q_a_o == 16'h0000) else $error("zero sample not silent");
endmodule // dnhm_chk

bind dnhm_top dnhm_chk chk_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .adc_a_i(adc_a_i), .adc_b_i(adc_b_i),
  .hop_pins_a_i(hop_pins_a_i), .hop_pins_b_i(hop_pins_b_i), .i_a_o(i_a_o),
  .q_a_o(q_a_o), .i_b_o(i_b_o), .q_b_o(q_b_o));

// File: tb.sv
// Self-checking bench of the NCO mixer: registers, bypass, selection, hops.
// Assumes the design's register map and its 36-cycle sample path.
`timescale 1ns/1ns
`include "dnhm_defs.vh"
module tb;
  reg clk_i = 1'b0;
  reg rst_b_i = 1'b0;
  reg [5:0] addr = 6'h00;
  reg [31:0] wdata = 32'h0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [11:0] lvl_a = 12'h400;
  reg [11:0] lvl_b = 12'h9C0;
  reg [1:0] hop_a = 2'h0;
  reg [1:0] hop_b = 2'h0;
  wire [31:0] rdata;
  wire [11:0] adc_a, adc_b;
  wire [15:0] ia, qa, ib, qb;
  wire [63:0] cos_t = 64'h0000_8001_0000_7FFF;
  wire [63:0] sin_t = 64'h8001_0000_7FFF_0000;
  wire [41:0] adr_t = {6'h02, 6'h0F, 6'h1F, 6'h17, 6'h10, 6'h01, 6'h00};
  integer err_count = 0;
  integer compares = 0;
  integer x, n;
  reg [31:0] v;
  reg [15:0] c0, c1;
  // ********************
  // Clock, partner, design
  // ********************
  initial forever #25 clk_i = ~clk_i;
  dnhm_adc_model pm (.clk_i(clk_i), .lvl_a_i(lvl_a), .lvl_b_i(lvl_b), .adc_a_o(adc_a),
    .adc_b_o(adc_b));
  dnhm_top uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .adc_a_i(adc_a), .adc_b_i(adc_b),
    .hop_pins_a_i(hop_a), .hop_pins_b_i(hop_b), .i_a_o(ia), .q_a_o(qa), .i_b_o(ib),
    .q_b_o(qb));
  // ********************
  // Helpers
  // ********************
  function [15:0] mix(input [11:0] s, input [15:0] t);
    reg signed [27:0] p;
    begin
      p = $signed(s) * $signed(t);
      mix = p[26:11];
    end
  endfunction
  // Expected I and Q pair for table entry k
  function [31:0] pair(input [11:0] s, input integer k);
    begin
      pair = {mix(s, cos_t[k*16 +: 16]), mix(s, sin_t[k*16 +: 16])};
    end
  endfunction
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wr_reg(input [5:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
    end
  endtask
  task rd_reg(input [5:0] a, output [31:0] d);
    begin
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1;
      d = rdata;
    end
  endtask
  task settle;
    begin
      repeat (45) @(posedge clk_i);
      #1;
    end
  endtask
  task final_report;
    begin
      if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // ********************
  // Tests
  // ********************
  initial begin
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (x = 0; x < 7; x = x + 1) begin
      rd_reg(adr_t[x*6 +: 6], v);
      chk("reset value", v, 32'h0);
    end
    settle;
    chk("bypass a", {ia, qa}, {lvl_a, 4'h0, 16'h0});
    chk("bypass b", {ib, qb}, {lvl_b, 4'h0, 16'h0});
    wr_reg(`DNHM_ADDR_RDIV, 32'hFFFF_1234);
    rd_reg(`DNHM_ADDR_RDIV, v);
    chk("divider", v, 32'h0000_1234);
    wr_reg(`DNHM_ADDR_RDIV, 32'h0);
    for (x = 0; x < 4; x = x + 1) begin
      wr_reg(6'(6'h18 + x), {16'hFFFF, x[1:0], 14'h0});
      wr_reg(6'(6'h1C + x), {16'h0, x[1:0], 14'h0});
    end
    // Register selection through every code
    for (x = 0; x < 4; x = x + 1) begin
      wr_reg(`DNHM_ADDR_CTRL, {24'h0, x[1:0], x[1:0], 4'h1});
      settle;
      chk("mix a", {ia, qa}, pair(lvl_a, x));
      chk("mix b", {ib, qb}, pair(lvl_b, x));
      rd_reg(`DNHM_ADDR_STATUS, v);
      chk("status sel", v[3:0], {x[1:0], x[1:0]});
    end
    // Pin selection, register field set against it, B bound to A
    wr_reg(`DNHM_ADDR_CTRL, 32'hF7);
    for (x = 0; x < 4; x = x + 1) begin
      @(posedge clk_i);
      hop_a <= x[1:0];
      hop_b <= ~x[1:0];
      settle;
      chk("hop a", {ia, qa}, pair(lvl_a, x));
      chk("hop b", {ib, qb}, pair(lvl_a, 3 - x));
      rd_reg(`DNHM_ADDR_STATUS, v);
      chk("status pins", v[7:0], {~x[1:0], x[1:0], ~x[1:0], x[1:0]});
    end
    // Hop latency from pin change to output
    @(posedge clk_i);
    hop_a <= 2'h1;
    n = 0;
    while (qa !== mix(lvl_a, 16'h7FFF) && n < 60) begin
      @(posedge clk_i);
      #1;
      n = n + 1;
    end
    chk("hop latency", (n >= 36 && n <= 40), 32'h1);
    // Half-turn tuning: accumulator wraps every second clock
    wr_reg(`DNHM_ADDR_CTRL, 32'h01);
    wr_reg(6'h10, 32'h8000_0000);
    settle;
    c0 = ia;
    c1 = (c0 == mix(lvl_a, 16'h7FFF)) ? mix(lvl_a, 16'h8001) : mix(lvl_a, 16'h7FFF);
    @(posedge clk_i);
    #1;
    chk("acc step", ia, c1);
    chk("acc level", (c0 == mix(lvl_a, 16'h7FFF) || c0 == mix(lvl_a, 16'h8001)), 32'h1);
    // Rational mode, zero step: the period wrap must clear the frozen phase
    wr_reg(6'h10, 32'h0);
    wr_reg(`DNHM_ADDR_RDIV, 32'h1);
    repeat (3) settle;
    chk("rational wrap", {ia, qa}, {mix(lvl_a, 16'h7FFF), 16'h0});
    // Silent input under the mixer gives silent output
    @(posedge clk_i);
    lvl_a <= 12'h000;
    settle;
    chk("mix zero", {ia, qa}, 32'h0);
    final_report;
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count = err_count + 1;
    final_report;
  end
endmodule // tb
